// >>> verilog/sec_drive.sv
// Drive end: security erase, erase prepare and freeze-lock handling
`timescale 1ns/1ns
module sec_drive #(
	parameter int BLOCK_W = 32
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               power_on_n,
	sec_link_if.drive               link,
	input  wire logic               lock_enabled_in,
	input  wire logic               lock_load,
	input  wire logic [255:0]       user_password,
	input  wire logic [255:0]       master_password,
	input  wire logic [BLOCK_W-1:0] native_max_block,
	input  wire logic               media_ready,
	output logic                    media_write,
	output logic [BLOCK_W-1:0]      media_block,
	output logic                    lock_enabled,
	output logic                    frozen,
	output logic [15:0]             erase_time_word
);
	typedef enum logic [1:0] {
		D_IDLE  = 2'b00,
		D_DATA  = 2'b01,
		D_ERASE = 2'b10
	} d_state_t;
	d_state_t     state;
	logic         prepared;
	logic [7:0]   idx;
	logic         sel_master;
	logic         mode_enh;
	logic         pw_match;
	logic [BLOCK_W-1:0] blk;
	logic [255:0] stored_pw;

	function automatic logic is_lock_cmd(input logic [7:0] c);
		return c == sec_erase_pkg::OP_SET_PASSWORD || c == sec_erase_pkg::OP_UNLOCK
			|| c == sec_erase_pkg::OP_DISABLE_PW || c == sec_erase_pkg::OP_ERASE_UNIT;
	endfunction : is_lock_cmd

	function automatic logic [255:0] selected_pw(input logic m);
		return m ? master_password : user_password;
	endfunction : selected_pw

	// Ready and seek done always stand; busy, data request and error vary
	function automatic logic [7:0] status_word(input logic busy, input logic drq, input logic err);
		logic [7:0] s;
		s = 8'h00;
		s[sec_erase_pkg::STS_READY_BIT] = 1'b1;
		s[sec_erase_pkg::STS_SEEK_DONE_BIT] = 1'b1;
		s[sec_erase_pkg::STS_BUSY_BIT] = busy;
		s[sec_erase_pkg::STS_DATA_REQ_BIT] = drq;
		s[sec_erase_pkg::STS_ERROR_BIT] = err;
		return s;
	endfunction : status_word

	function automatic logic [7:0] error_word(input logic aborted);
		logic [7:0] e;
		e = sec_erase_pkg::ERR_RESET;
		e[sec_erase_pkg::ERR_ABORTED_BIT] = aborted;
		return e;
	endfunction : error_word

	// Enhanced erase refused: zero fill is the only mode built
	function automatic logic erase_refused(input logic lock_on, input logic master, input logic match, input logic enh);
		return (!lock_on && !master)
			|| (lock_on && !match)
			|| enh;
	endfunction : erase_refused

	// ------------------------------------------------------------
	// Stored password picked by the selector
	// ------------------------------------------------------------
	assign stored_pw = selected_pw(sel_master);

	// ------------------------------------------------------------
	// Frozen state; cleared by power-on only, not by rst_n
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!power_on_n)
			frozen <= 1'b0;
		else if (link.cmd_valid && link.cmd_code == sec_erase_pkg::OP_FREEZE && state == D_IDLE)
			frozen <= 1'b1;
	end

	// ------------------------------------------------------------
	// Prepare marker; only the command right before erase counts
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n)
			prepared <= 1'b0;
		else if (link.cmd_valid && state == D_IDLE)
			prepared <= (link.cmd_code == sec_erase_pkg::OP_ERASE_PREP);
	end

	// ------------------------------------------------------------
	// Identification word with the erase time
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n)
			erase_time_word <= sec_erase_pkg::ERASE_TIME_MIN;
	end

	// ------------------------------------------------------------
	// Command engine
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= D_IDLE;
			idx <= 8'h00;
			sel_master <= 1'b0;
			mode_enh <= 1'b0;
			pw_match <= 1'b1;
			blk <= '0;
			lock_enabled <= 1'b0;
			media_write <= 1'b0;
			media_block <= '0;
			link.done <= 1'b0;
			link.command_error_flags <= sec_erase_pkg::ERR_RESET;
			link.command_status_flags <= sec_erase_pkg::STS_RESET;
		end else begin
			link.done <= 1'b0;
			media_write <= 1'b0;
			if (lock_load && state == D_IDLE)
				lock_enabled <= lock_enabled_in;
			unique case (state)
				D_IDLE: begin
					if (link.cmd_valid) begin
						link.command_error_flags <= error_word(1'b0);
						if (frozen && is_lock_cmd(link.cmd_code)) begin
							link.command_error_flags <= error_word(1'b1);
							link.command_status_flags <= status_word(1'b0, 1'b0, 1'b1);
							link.done <= 1'b1;
						end else if (link.cmd_code == sec_erase_pkg::OP_ERASE_UNIT) begin
							if (!prepared) begin
								link.command_error_flags <= error_word(1'b1);
								link.command_status_flags <= status_word(1'b0, 1'b0, 1'b1);
								link.done <= 1'b1;
							end else begin
								link.command_status_flags <= status_word(1'b0, 1'b1, 1'b0);
								idx <= 8'h00;
								pw_match <= 1'b1;
								state <= D_DATA;
							end
						end else begin
							// Prepare, freeze and others finish with no data
							link.command_status_flags <= sec_erase_pkg::STS_RESET;
							link.done <= 1'b1;
						end
					end
				end
				D_DATA: begin
					if (link.data_valid) begin
						idx <= idx + 8'h01;
						if (idx == 8'h00) begin
							sel_master <= link.data_word[sec_erase_pkg::CTRL_SEL_BIT];
							mode_enh <= link.data_word[sec_erase_pkg::CTRL_MODE_BIT];
						end else if (idx <= 8'(sec_erase_pkg::PW_LAST_WORD)) begin
							if (link.data_word != stored_pw[(16 * (int'(idx) - 1)) +: 16])
								pw_match <= 1'b0;
						end
						// Words past the password are ignored
						if (idx == 8'(sec_erase_pkg::SECTOR_WORDS - 1)) begin
							if (erase_refused(lock_enabled, sel_master, pw_match, mode_enh)) begin
								link.command_error_flags <= error_word(1'b1);
								link.command_status_flags <= status_word(1'b0, 1'b0, 1'b1);
								link.done <= 1'b1;
								state <= D_IDLE;
							end else begin
								link.command_status_flags <= status_word(1'b1, 1'b0, 1'b0);
								blk <= '0;
								state <= D_ERASE;
							end
						end
					end
				end
				D_ERASE: begin
					// Writes zeros only; defect lists are not touched
					if (media_ready && !media_write) begin
						media_write <= 1'b1;
						media_block <= blk;
						blk <= blk + BLOCK_W'(1);
						if (blk == native_max_block) begin
							lock_enabled <= 1'b0;
							link.command_status_flags <= sec_erase_pkg::STS_RESET;
							link.done <= 1'b1;
							state <= D_IDLE;
						end
					end
				end
				default: state <= D_IDLE;
			endcase
		end
	end
endmodule : sec_drive

// >>> verilog/sec_erase_pkg.sv
// Constants shared by both ends of the security command link
package sec_erase_pkg;
	// ------------------------------------------------------------
	// Command opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_ERASE_PREP   = 8'hF3;
	localparam logic [7:0] OP_ERASE_UNIT   = 8'hF4;
	localparam logic [7:0] OP_FREEZE       = 8'hF5;
	localparam logic [7:0] OP_SET_PASSWORD = 8'hF1;
	localparam logic [7:0] OP_UNLOCK       = 8'hF2;
	localparam logic [7:0] OP_DISABLE_PW   = 8'hF6;
	// ------------------------------------------------------------
	// Error and status register fields
	// ------------------------------------------------------------
	localparam int ERR_ABORTED_BIT   = 2;
	localparam int ERR_ID_NOT_FOUND  = 4;
	localparam int STS_BUSY_BIT      = 7;
	localparam int STS_READY_BIT     = 6;
	localparam int STS_SEEK_DONE_BIT = 4;
	localparam int STS_DATA_REQ_BIT  = 3;
	localparam int STS_ERROR_BIT     = 0;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [7:0] STS_RESET = 8'h50;
	// ------------------------------------------------------------
	// Parameter sector layout
	// ------------------------------------------------------------
	localparam int SECTOR_WORDS  = 256;
	localparam int PW_FIRST_WORD = 1;
	localparam int PW_LAST_WORD  = 16;
	localparam int CTRL_SEL_BIT  = 0;
	localparam int CTRL_MODE_BIT = 1;
	localparam logic [15:0] ERASE_TIME_MIN = 16'h0010;
endpackage : sec_erase_pkg

// >>> verilog/sec_link_if.sv
// Task-file command link between host adapter and drive
`timescale 1ns/1ns
interface sec_link_if;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic        data_valid;
	logic [15:0] data_word;
	logic [7:0]  command_error_flags;
	logic [7:0]  command_status_flags;
	logic        done;
	modport drive (input cmd_valid, cmd_code, data_valid, data_word,
		output command_error_flags, command_status_flags, done);
	modport host (output cmd_valid, cmd_code, data_valid, data_word,
		input command_error_flags, command_status_flags, done);
endinterface : sec_link_if

// >>> verilog/sec_host.sv
// Host adapter end: issues commands and streams parameter sectors
`timescale 1ns/1ns
module sec_host (
	input  wire logic        clk,
	input  wire logic        rst_n,
	sec_link_if.host         link,
	input  wire logic        req,
	input  wire logic [7:0]  req_code,
	input  wire logic        req_master,
	input  wire logic        req_enhanced,
	input  wire logic [255:0] req_password,
	output logic             ready,
	output logic             ack,
	output logic             ack_aborted
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WAIT = 2'b01,
		H_SEND = 2'b10,
		H_END  = 2'b11
	} h_state_t;
	h_state_t    state;
	logic [7:0]  idx;
	logic [7:0]  code;
	logic [15:0] word_val;

	// ------------------------------------------------------------
	// Word being sent; reserved words go out as zero
	// ------------------------------------------------------------
	always_comb begin
		word_val = 16'h0000;
		if (idx == 8'h00)
			word_val = {14'h0000, req_enhanced, req_master};
		else if (idx <= 8'(sec_erase_pkg::PW_LAST_WORD))
			word_val = req_password[(16 * (int'(idx) - 1)) +: 16];
	end

	// ------------------------------------------------------------
	// Command sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= H_IDLE;
			idx <= 8'h00;
			code <= 8'h00;
			link.cmd_valid <= 1'b0;
			link.cmd_code <= 8'h00;
			link.data_valid <= 1'b0;
			link.data_word <= 16'h0000;
			ready <= 1'b0;
			ack <= 1'b0;
			ack_aborted <= 1'b0;
		end else begin
			link.cmd_valid <= 1'b0;
			link.data_valid <= 1'b0;
			ack <= 1'b0;
			ready <= 1'b0;
			unique case (state)
				H_IDLE: begin
					ready <= !req;
					if (req) begin
						// Caller orders prepare before erase
						link.cmd_valid <= 1'b1;
						link.cmd_code <= req_code;
						code <= req_code;
						idx <= 8'h00;
						state <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (link.done) begin
						ack <= 1'b1;
						ack_aborted <= link.command_error_flags[sec_erase_pkg::ERR_ABORTED_BIT];
						state <= H_IDLE;
					end else if (link.command_status_flags[sec_erase_pkg::STS_DATA_REQ_BIT]
						&& code == sec_erase_pkg::OP_ERASE_UNIT) begin
						state <= H_SEND;
					end
				end
				H_SEND: begin
					link.data_valid <= 1'b1;
					link.data_word <= word_val;
					idx <= idx + 8'h01;
					// Status still shows data request here, so a second sector must not start
					if (idx == 8'(sec_erase_pkg::SECTOR_WORDS - 1))
						state <= H_END;
				end
				H_END: begin
					if (link.done) begin
						ack <= 1'b1;
						ack_aborted <= link.command_error_flags[sec_erase_pkg::ERR_ABORTED_BIT];
						state <= H_IDLE;
					end
				end
			endcase
		end
	end
endmodule : sec_host

// >>> tb/sec_link_properties.sv
// Concurrent checks on the security command link
`timescale 1ns/1ns
module sec_link_properties (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        data_valid,
	input wire logic [15:0] data_word,
	input wire logic [7:0]  command_error_flags,
	input wire logic [7:0]  command_status_flags,
	input wire logic        done
);
	// ------------------------------------------------------------
	// Helpers and properties
	// ------------------------------------------------------------
	logic [8:0] word_cnt;
	logic       after_prep;
	logic       idle;
	// Not busy and no data phase open: only then is a command taken
	assign idle = !command_status_flags[7] && !command_status_flags[3];
	always_ff @(posedge clk) begin
		if (!rst_n || cmd_valid) word_cnt <= 9'h000;
		else if (data_valid) word_cnt <= word_cnt + 9'h001;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) after_prep <= 1'b0;
		else if (cmd_valid && idle) after_prep <= (cmd_code == 8'hF3);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_PREP_NO_DATA: assert property (cmd_valid && idle && cmd_code == 8'hF3 |=> done && command_status_flags == 8'h50)
		else $error("prepare did not finish at once");
	AST_ERASE_ASKS_DATA: assert property (cmd_valid && idle && cmd_code == 8'hF4 && after_prep
		|=> (command_status_flags == 8'h58 && !done) || (done && command_error_flags[2]))
		else $error("erase did not open its data phase");
	AST_NO_PREP_ABORT: assert property (cmd_valid && idle && cmd_code == 8'hF4 && !after_prep
		|=> done && command_error_flags[2])
		else $error("erase without prepare was not aborted");
	AST_SECTOR_LEN: assert property (data_valid |-> word_cnt <= 9'h0FF)
		else $error("more than one sector sent");
	AST_LAST_WORD: assert property (data_valid && word_cnt == 9'h0FF
		|=> command_status_flags == 8'hD0 || (done && command_error_flags[2]))
		else $error("no verdict after the last parameter word");
	AST_RESERVED_ZERO: assert property (data_valid && word_cnt > 9'h010 |-> data_word == 16'h0000)
		else $error("reserved parameter word not zero");
	AST_CTRL_RESERVED: assert property (data_valid && word_cnt == 9'h000 |-> data_word[15:2] == 14'h0000)
		else $error("reserved control bits not zero");
	AST_DONE_FLAGS: assert property (done |-> !command_status_flags[7]
		&& command_status_flags[0] == command_error_flags[2] ##1 !done)
		else $error("completion flags inconsistent");
	AST_FREEZE_AT_ONCE: assert property (cmd_valid && idle && cmd_code == 8'hF5 |=> done && !command_error_flags[2])
		else $error("freeze not completed at once");
	COV_SECTOR: cover property (data_valid && word_cnt == 9'h0FF);
	COV_ABORT: cover property (done && command_error_flags[2]);
	COV_FREEZE: cover property (cmd_valid && cmd_code == 8'hF5);
endmodule : sec_link_properties

// >>> tb/drive_security_erase_freeze_bench.sv
// Bench joining host and drive ends of the security link
`timescale 1ns/1ns
module drive_security_erase_freeze_bench;
	// ------------------------------------------------------------
	// Stimulus, instances and scenarios
	// ------------------------------------------------------------
	localparam logic [255:0] USER_PW = {16{16'hA5C3}};
	localparam logic [255:0] MAST_PW = {16{16'h3C5A}};
	localparam logic [31:0]  MAX_BLK = 32'h00000003;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         power_on_n = 1'b0;
	logic         req = 1'b0;
	logic [7:0]   req_code = 8'h00;
	logic         req_master = 1'b0;
	logic         req_enhanced = 1'b0;
	logic [255:0] req_password = '0;
	logic         lock_enabled_in = 1'b1;
	logic         lock_load = 1'b0;
	logic         ready, ack, ack_aborted, media_write, lock_enabled, frozen;
	logic [31:0]  media_block, first_blk, top_blk;
	logic [15:0]  erase_time_word;
	int           error_cnt = 0;
	int           checks = 0;
	int           wr_cnt = 0;
	sec_link_if link ();
	sec_host sec_host_i (.clk(clk), .rst_n(rst_n), .link(link), .req(req), .req_code(req_code),
		.req_master(req_master), .req_enhanced(req_enhanced), .req_password(req_password),
		.ready(ready), .ack(ack), .ack_aborted(ack_aborted));
	// Short media keeps the zero fill to four blocks
	sec_drive #(.BLOCK_W(32)) sec_drive_i (.clk(clk), .rst_n(rst_n), .power_on_n(power_on_n), .link(link),
		.lock_enabled_in(lock_enabled_in), .lock_load(lock_load), .user_password(USER_PW),
		.master_password(MAST_PW), .native_max_block(MAX_BLK), .media_ready(1'b1), .media_write(media_write),
		.media_block(media_block), .lock_enabled(lock_enabled), .frozen(frozen), .erase_time_word(erase_time_word));
	sec_link_properties sec_link_properties_i (.clk(clk), .rst_n(rst_n), .cmd_valid(link.cmd_valid),
		.cmd_code(link.cmd_code), .data_valid(link.data_valid), .data_word(link.data_word),
		.command_error_flags(link.command_error_flags), .command_status_flags(link.command_status_flags),
		.done(link.done));
	initial begin
		forever #2 clk = ~clk;
	end
	// Write count restarts with every command, so no task has to clear it
	always @(posedge clk) begin
		if (link.cmd_valid === 1'b1) begin
			wr_cnt <= 0;
		end else if (media_write === 1'b1) begin
			if (wr_cnt == 0) first_blk <= media_block;
			top_blk <= media_block;
			wr_cnt <= wr_cnt + 1;
		end
	end
	task automatic conclude();
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wait_hi(ref logic s);
		for (int n = 0; s !== 1'b1; n++) begin
			if (n == 3000) begin
				error_cnt++;
				conclude();
			end
			@(negedge clk);
		end
	endtask : wait_hi
	// Request held from one falling edge across the taking edge
	task automatic op(input logic [7:0] c, input logic m, input logic e, input logic [255:0] pw, input logic ab);
		wait_hi(ready);
		{req_code, req_master, req_enhanced, req_password} = {c, m, e, pw};
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		wait_hi(ack);
		chk("aborted", {31'h0, ab}, {31'h0, ack_aborted});
		chk("error flags", ab ? 32'h04 : 32'h00, {24'h0, link.command_error_flags});
		chk("status", ab ? 32'h51 : 32'h50, {24'h0, link.command_status_flags});
		@(negedge clk);
	endtask : op
	task automatic set_lock(input logic v);
		lock_enabled_in = v;
		lock_load = 1'b1;
		@(negedge clk);
		lock_load = 1'b0;
		@(negedge clk);
	endtask : set_lock
	task automatic t_erase_ok();
		set_lock(1'b1);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b0, 1'b0, USER_PW, 1'b0);
		chk("writes", MAX_BLK + 32'h1, wr_cnt);
		chk("first block", 32'h0, first_blk);
		chk("top block", MAX_BLK, top_blk);
		chk("lock", 32'h0, {31'h0, lock_enabled});
		chk("erase time", 32'h0010, {16'h0, erase_time_word});
	endtask : t_erase_ok
	task automatic t_refusals();
		set_lock(1'b1);
		op(8'hF4, 1'b0, 1'b0, USER_PW, 1'b1);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b0, 1'b0, MAST_PW, 1'b1);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b0, 1'b1, USER_PW, 1'b1);
		set_lock(1'b0);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b0, 1'b0, USER_PW, 1'b1);
	endtask : t_refusals
	task automatic t_master();
		set_lock(1'b1);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b1, 1'b0, MAST_PW, 1'b0);
		set_lock(1'b0);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b1, 1'b0, USER_PW, 1'b0);
		chk("writes", MAX_BLK + 32'h1, wr_cnt);
	endtask : t_master
	task automatic t_freeze();
		logic [7:0] codes [3] = '{8'hF1, 8'hF2, 8'hF6};
		op(8'hF5, 1'b0, 1'b0, '0, 1'b0);
		chk("frozen", 32'h1, {31'h0, frozen});
		foreach (codes[i]) op(codes[i], 1'b0, 1'b0, USER_PW, 1'b1);
		op(8'hF3, 1'b0, 1'b0, '0, 1'b0);
		op(8'hF4, 1'b0, 1'b0, USER_PW, 1'b1);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("frozen", 32'h1, {31'h0, frozen});
		power_on_n = 1'b0;
		@(negedge clk);
		power_on_n = 1'b1;
		@(negedge clk);
		chk("frozen", 32'h0, {31'h0, frozen});
	endtask : t_freeze
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		power_on_n = 1'b1;
		chk("reset status", 32'h50, {24'h0, link.command_status_flags});
		t_erase_ok();
		t_refusals();
		t_master();
		t_freeze();
		conclude();
	end
endmodule : drive_security_erase_freeze_bench
